/* File: tlsm_pkg.sv */
// constants and types shared by the travel limit switch monitor
package tlsm_pkg;
  // ----------------------------------------------------------------
  // parameter addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] TLSM_ADDR_NEG_EVAL = 16'h061e;
  localparam logic [15:0] TLSM_ADDR_POS_EVAL = 16'h0620;

  // ----------------------------------------------------------------
  // switch evaluation codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  TLSM_EVAL_OFF      = 2'h0;
  localparam logic [1:0]  TLSM_EVAL_NC       = 2'h1;
  localparam logic [1:0]  TLSM_EVAL_NO       = 2'h2;
  localparam logic [1:0]  TLSM_EVAL_RST      = TLSM_EVAL_NC;
  localparam logic [15:0] TLSM_EVAL_MAX      = 16'h0002;

  // ----------------------------------------------------------------
  // operating states
  // ----------------------------------------------------------------
  localparam logic [3:0]  TLSM_OPST_ENABLED  = 4'h6;
  localparam logic [3:0]  TLSM_OPST_QSTOP    = 4'h7;

  typedef enum logic [1:0] {
    TLSM_LAST_NONE,
    TLSM_LAST_POS,
    TLSM_LAST_NEG
  } tlsm_last_t;
endpackage

/* File: tlsm_lim_if.sv */
// interface between one switch evaluator and the monitor
`timescale 1ns/1ps
interface tlsm_lim_if;
  logic       tripped;
  logic [1:0] act_cfg;
  modport eval (output tripped, output act_cfg);
  modport mon  (input tripped, input act_cfg);
endinterface // tlsm_lim_if

/* File: tlsm_lim_eval.sv */
// one limit switch input: synchroniser, active setting, trip decode
`timescale 1ns/1ps
module tlsm_lim_eval
  import tlsm_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       pin_in,
  input wire logic       pwr_on_pulse,
  input wire logic [1:0] new_cfg,
  tlsm_lim_if.eval       lim
);
  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [1:0] cfg;
    logic       trip;
  } tlsm_eval_st_t;

  tlsm_eval_st_t s_ff;
  tlsm_eval_st_t nxt_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.sync1 = pin_in;
    nxt_s.sync2 = s_ff.sync1;
    if (pwr_on_pulse) begin
      nxt_s.cfg = new_cfg;
    end
    case (s_ff.cfg)
      TLSM_EVAL_NC: nxt_s.trip = ~s_ff.sync2; // RQ12
      TLSM_EVAL_NO: nxt_s.trip = s_ff.sync2;  // RQ12
      default:      nxt_s.trip = 1'b0;        // RQ12
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      // closed contact idle level, no false trip after reset
      s_ff <= '{1'b1, 1'b1, TLSM_EVAL_RST, 1'b0}; // RQ12
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lim.tripped = s_ff.trip;
  assign lim.act_cfg = s_ff.cfg;
endmodule // tlsm_lim_eval

/* File: tlsm_monitor.sv */
// travel limit switch monitor top
`timescale 1ns/1ps
// Function
// (RQ1) watch a positive and a negative end-of-travel switch input
// (RQ2) stop motion as soon as either switch trips
// (RQ3) on a trip raise the error and enter operating state 7
// (RQ4) fault reset clears the error and returns to state 6
// (RQ5) after a trip allow only motion away from that switch
// (RQ6) motion toward the tripped switch raises error and state 7 again
// (RQ7) positive input: 0 inactive, 1 normally closed, 2 normally open
// (RQ8) negative input uses the same three codes
// (RQ9) setting writes are refused while the power stage is enabled
// (RQ10) new setting takes effect at the next power stage enable
// (RQ11) integrator maps both switch functions to physical inputs
// (RQ12) closed type trips when low, open type when high, off never
// (RQ13) remember which switch tripped last to block that direction
module tlsm_monitor
  import tlsm_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        positive_travel_input_function,
  input  wire logic        negative_travel_input_function,
  input  wire logic        power_stage_en,
  input  wire logic        fault_reset,
  input  wire logic        move_req_pos,
  input  wire logic        move_req_neg,
  input  wire logic        par_wr_en,
  input  wire logic        par_rd_en,
  input  wire logic [15:0] par_addr,
  input  wire logic [15:0] par_wdata,
  output logic [15:0]      par_rdata,
  output logic             par_ack,
  output logic             par_err,
  output logic             move_stop,
  output logic             limit_error,
  output logic [3:0]       op_state,
  output logic             allow_pos,
  output logic             allow_neg
);
  typedef struct packed {
    logic        pwr_d;
    logic        err;
    logic [3:0]  opst;
    tlsm_last_t  last;
    logic        blk_pos;
    logic        blk_neg;
    logic        trip_pos_d;
    logic        trip_neg_d;
    logic        stop;
    logic        allow_pos;
    logic        allow_neg;
    logic [1:0]  pend_pos;
    logic [1:0]  pend_neg;
    logic [15:0] rdata;
    logic        ack;
    logic        perr;
  } tlsm_mon_st_t;

  tlsm_mon_st_t s_ff;
  tlsm_mon_st_t nxt_s;
  logic         pwr_on_pulse;
  logic         pos_ev;
  logic         neg_ev;
  logic         viol;
  logic         set_err;
  logic         wr_ok;

  tlsm_lim_if pos_if ();
  tlsm_lim_if neg_if ();

  // ----------------------------------------------------------------
  // switch evaluators
  // ----------------------------------------------------------------
  tlsm_lim_eval u_pos (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (positive_travel_input_function),
    .pwr_on_pulse (pwr_on_pulse),
    .new_cfg      (s_ff.pend_pos),
    .lim          (pos_if)
  );

  tlsm_lim_eval u_neg (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .pin_in       (negative_travel_input_function),
    .pwr_on_pulse (pwr_on_pulse),
    .new_cfg      (s_ff.pend_neg),
    .lim          (neg_if)
  );

  // ----------------------------------------------------------------
  // events
  // ----------------------------------------------------------------
  assign pwr_on_pulse = power_stage_en & ~s_ff.pwr_d; // RQ10
  assign pos_ev  = pos_if.tripped & ~s_ff.trip_pos_d; // RQ1
  assign neg_ev  = neg_if.tripped & ~s_ff.trip_neg_d; // RQ1
  assign viol    = (move_req_pos & s_ff.blk_pos)
                 | (move_req_neg & s_ff.blk_neg);     // RQ6
  assign set_err = pos_ev | neg_ev | viol;
  assign wr_ok   = ~power_stage_en & (par_wdata <= TLSM_EVAL_MAX); // RQ9

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s            = s_ff;
    nxt_s.pwr_d      = power_stage_en;
    nxt_s.trip_pos_d = pos_if.tripped;
    nxt_s.trip_neg_d = neg_if.tripped;
    // motion away from the blocked end lifts the block
    if (!s_ff.err && move_req_neg && s_ff.blk_pos && !pos_if.tripped) begin
      nxt_s.blk_pos = 1'b0; // RQ5
    end
    if (!s_ff.err && move_req_pos && s_ff.blk_neg && !neg_if.tripped) begin
      nxt_s.blk_neg = 1'b0; // RQ5
    end
    if (pos_ev) begin
      nxt_s.last    = TLSM_LAST_POS; // RQ13
      nxt_s.blk_pos = 1'b1;          // RQ13
      nxt_s.blk_neg = 1'b0;
    end else if (neg_ev) begin
      nxt_s.last    = TLSM_LAST_NEG; // RQ13
      nxt_s.blk_neg = 1'b1;          // RQ13
      nxt_s.blk_pos = 1'b0;
    end
    if (fault_reset && s_ff.err) begin
      nxt_s.err  = 1'b0;              // RQ4
      nxt_s.opst = TLSM_OPST_ENABLED; // RQ4
    end
    if (set_err) begin
      nxt_s.err  = 1'b1;            // RQ3
      nxt_s.opst = TLSM_OPST_QSTOP; // RQ3
    end
    nxt_s.stop      = nxt_s.err;                     // RQ2
    nxt_s.allow_pos = ~nxt_s.err & ~nxt_s.blk_pos;   // RQ5
    nxt_s.allow_neg = ~nxt_s.err & ~nxt_s.blk_neg;   // RQ5
    // parameter access
    nxt_s.ack   = par_wr_en | par_rd_en;
    nxt_s.perr  = 1'b0;
    nxt_s.rdata = '0;
    if (par_wr_en || par_rd_en) begin
      case (par_addr)
        TLSM_ADDR_NEG_EVAL: begin
          nxt_s.rdata = 16'(s_ff.pend_neg);
          if (par_wr_en) begin
            if (wr_ok) begin
              nxt_s.pend_neg = par_wdata[1:0]; // RQ8
            end else begin
              nxt_s.perr = 1'b1; // RQ9
            end
          end
        end
        TLSM_ADDR_POS_EVAL: begin
          nxt_s.rdata = 16'(s_ff.pend_pos);
          if (par_wr_en) begin
            if (wr_ok) begin
              nxt_s.pend_pos = par_wdata[1:0]; // RQ7
            end else begin
              nxt_s.perr = 1'b1; // RQ9
            end
          end
        end
        default: nxt_s.perr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_ff <= '{1'b0, 1'b0, TLSM_OPST_ENABLED, TLSM_LAST_NONE, 1'b0, 1'b0,
                1'b0, 1'b0, 1'b0, 1'b1, 1'b1, TLSM_EVAL_RST, TLSM_EVAL_RST,
                16'h0000, 1'b0, 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign par_rdata   = s_ff.rdata;
  assign par_ack     = s_ff.ack;
  assign par_err     = s_ff.perr;
  assign move_stop   = s_ff.stop;
  assign limit_error = s_ff.err;
  assign op_state    = s_ff.opst;
  assign allow_pos   = s_ff.allow_pos;
  assign allow_neg   = s_ff.allow_neg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence qstop_entry;
    (pos_ev || neg_ev) ##1 (s_ff.opst == TLSM_OPST_QSTOP);
  endsequence

  a_trip_stops: assert property ((pos_ev || neg_ev) |=> // RQ2
    (move_stop && !allow_pos && !allow_neg))
    else $error("trip did not stop motion");
  a_trip_qstop: assert property (qstop_entry ##0 !fault_reset // RQ3
    |=> limit_error && op_state == TLSM_OPST_QSTOP)
    else $error("trip did not hold quick stop");
  a_fault_clear: assert property ((fault_reset && limit_error // RQ4
    && !set_err) |=> (!limit_error && op_state == TLSM_OPST_ENABLED))
    else $error("fault reset did not clear error");
  a_block_dir: assert property ((fault_reset && limit_error // RQ5
    && s_ff.last == TLSM_LAST_POS && !set_err)
    |=> (!allow_pos && allow_neg))
    else $error("direction block wrong after reset");
  a_retrip_dir: assert property ((move_req_pos && s_ff.blk_pos) // RQ6
    |=> (limit_error && op_state == TLSM_OPST_QSTOP))
    else $error("move toward blocked end not refused");
  a_pos_off: assert property ((pos_if.act_cfg == TLSM_EVAL_OFF) [*2] // RQ7
    |-> !pos_if.tripped)
    else $error("inactive positive input tripped");
  a_neg_off: assert property ((neg_if.act_cfg == TLSM_EVAL_OFF) [*2] // RQ8
    |-> !neg_if.tripped)
    else $error("inactive negative input tripped");
  a_wr_reject: assert property ((par_wr_en && power_stage_en) // RQ9
    |=> (par_err && $stable(s_ff.pend_pos) && $stable(s_ff.pend_neg)))
    else $error("write accepted with power stage on");
  a_cfg_hold: assert property (!pwr_on_pulse // RQ10
    |=> ($stable(pos_if.act_cfg) && $stable(neg_if.act_cfg)))
    else $error("active setting changed without enable");
  a_cfg_take: assert property (pwr_on_pulse // RQ10
    |=> (pos_if.act_cfg == $past(s_ff.pend_pos)))
    else $error("setting not taken at enable");
  a_last_pos: assert property (pos_ev |=> s_ff.last == TLSM_LAST_POS) // RQ13
    else $error("last trip not recorded");
endmodule // tlsm_monitor

/* File: tlsm_switch_model.sv */
// contact model of the two end-of-travel switches
`timescale 1ns/1ps
module tlsm_switch_model (
  input  wire logic       clk_sys,
  input  wire logic       pos_hit,
  input  wire logic       neg_hit,
  input  wire logic [1:0] pos_type,
  input  wire logic [1:0] neg_type,
  output logic            pos_pin,
  output logic            neg_pin
);
  logic noise = 1'b0;
  // unwired input floats: changes every cycle
  always @(posedge clk_sys) noise <= ~noise;
  function automatic logic lvl(logic [1:0] t, logic hit, logic n);
    return (t == 2'h2) ? hit : ((t == 2'h1) ? ~hit : n);
  endfunction
  // each switch function wired to its own pin
  assign pos_pin = lvl(pos_type, pos_hit, noise);
  assign neg_pin = lvl(neg_type, neg_hit, noise);
endmodule // tlsm_switch_model

/* File: test_tlsm_monitor.sv */
// self-checking bench of the travel limit switch monitor
`timescale 1ns/1ps
module test_tlsm_monitor
  import tlsm_pkg::*;
;
  typedef struct packed {
    logic        e;
    logic        r;
    logic [15:0] d;
  } tlsm_note_t;
  logic        clk_sys, rst_n, power_stage_en, fault_reset;
  logic        move_req_pos, move_req_neg, par_wr_en, par_rd_en;
  logic [15:0] par_addr, par_wdata, par_rdata, v;
  logic        par_ack, par_err, move_stop, limit_error;
  logic [3:0]  op_state;
  logic        allow_pos, allow_neg, pos_hit, neg_hit;
  logic [1:0]  pos_type, neg_type;
  logic        positive_travel_input_function;
  logic        negative_travel_input_function;
  logic [15:0] seed = 16'hc46c;
  tlsm_note_t  q[$];
  tlsm_note_t  nt;
  int          n_mismatch = 0;
  int          checks_done = 0;
  tlsm_monitor dut (.clk_sys, .rst_n, .positive_travel_input_function,
    .negative_travel_input_function, .power_stage_en, .fault_reset,
    .move_req_pos, .move_req_neg, .par_wr_en, .par_rd_en, .par_addr,
    .par_wdata, .par_rdata, .par_ack, .par_err, .move_stop,
    .limit_error, .op_state, .allow_pos, .allow_neg);
  tlsm_switch_model sw (.clk_sys, .pos_hit, .neg_hit, .pos_type,
    .neg_type, .pos_pin(positive_travel_input_function),
    .neg_pin(negative_travel_input_function));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function logic [15:0] xs();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed;
  endfunction
  task cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task op(input logic w, input logic [15:0] a, input logic [15:0] d,
          input logic e, input logic [15:0] x);
    @(posedge clk_sys);
    par_wr_en <= w;
    par_rd_en <= !w;
    par_addr  <= a;
    par_wdata <= d;
    q.push_back('{e, !w, x});
    @(posedge clk_sys);
    par_wr_en <= 1'b0;
    par_rd_en <= 1'b0;
  endtask
  task fr();
    @(posedge clk_sys);
    fault_reset <= 1'b1;
    @(posedge clk_sys);
    fault_reset <= 1'b0;
    @(negedge clk_sys);
  endtask
  task wt();
    int i;
    i = 0;
    while (limit_error !== 1'b1 && i < 8) begin
      @(negedge clk_sys);
      i++;
    end
    if (i == 8) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // ----------------------------------------------------------------
  // answer watcher
  // ----------------------------------------------------------------
  always @(negedge clk_sys) begin
    if (par_ack === 1'b1) begin
      if (q.size() == 0) chk(16'h0001, 16'h0000);
      else begin
        nt = q.pop_front();
        chk(par_err, nt.e);
        if (nt.r) chk(par_rdata, nt.d);
      end
    end
  end
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, power_stage_en, fault_reset, move_req_pos} = 4'h0;
    {move_req_neg, par_wr_en, par_rd_en, pos_hit, neg_hit} = 5'h00;
    {par_addr, par_wdata, pos_type, neg_type} = {32'h0, 4'h5};
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    cyc(1);
    chk({op_state, allow_pos, allow_neg}, {TLSM_OPST_ENABLED, 2'h3});
    op(0, TLSM_ADDR_POS_EVAL, 16'h0000, 0, 16'h0001);
    op(0, TLSM_ADDR_NEG_EVAL, 16'h0000, 0, 16'h0001);
    op(0, 16'h0622, 16'h0000, 1, 16'h0000);
    for (int k = 0; k < 6; k++) begin
      v = xs() & 16'h0007;
      op(1, TLSM_ADDR_NEG_EVAL, v, v > TLSM_EVAL_MAX, 16'h0000);
      if (v <= TLSM_EVAL_MAX) op(0, TLSM_ADDR_NEG_EVAL, 16'h0000, 0, v);
    end
    op(1, TLSM_ADDR_NEG_EVAL, 16'h0001, 0, 16'h0000);
    @(posedge clk_sys);
    power_stage_en <= 1'b1;
    op(1, TLSM_ADDR_POS_EVAL, 16'h0002, 1, 16'h0000);
    op(0, TLSM_ADDR_POS_EVAL, 16'h0000, 0, 16'h0001);
    @(posedge clk_sys);
    pos_hit <= 1'b1;
    wt();
    chk({move_stop, op_state, allow_pos, allow_neg}, 16'h005c);
    fr();
    chk({limit_error, op_state, allow_pos, allow_neg}, 16'h0019);
    @(posedge clk_sys);
    move_req_pos <= 1'b1;
    cyc(2);
    chk({limit_error, op_state}, 16'h0017);
    @(posedge clk_sys);
    move_req_pos <= 1'b0;
    pos_hit <= 1'b0;
    cyc(4);
    fr();
    @(posedge clk_sys);
    move_req_neg <= 1'b1;
    @(posedge clk_sys);
    move_req_neg <= 1'b0;
    cyc(2);
    chk(allow_pos, 1'b1);
    @(posedge clk_sys);
    power_stage_en <= 1'b0;
    op(1, TLSM_ADDR_NEG_EVAL, 16'h0002, 0, 16'h0000);
    op(1, TLSM_ADDR_POS_EVAL, 16'h0000, 0, 16'h0000);
    @(posedge clk_sys);
    pos_type <= TLSM_EVAL_OFF;
    neg_type <= TLSM_EVAL_NO;
    wt();
    @(posedge clk_sys);
    power_stage_en <= 1'b1;
    cyc(4);
    fr();
    cyc(8);
    chk(limit_error, 1'b0);
    @(posedge clk_sys);
    neg_hit <= 1'b1;
    wt();
    fr();
    chk({limit_error, allow_pos, allow_neg}, 16'h0002);
    @(posedge clk_sys);
    move_req_neg <= 1'b1;
    cyc(2);
    chk({limit_error, op_state}, 16'h0017);
    @(posedge clk_sys);
    move_req_neg <= 1'b0;
    cyc(3);
    chk(16'(q.size()), 16'h0000);
    tally_and_finish();
  end
endmodule // test_tlsm_monitor
